// ==== core/mbh_host_port.sv ====
// multiplexed address/data bus port with self-detected host style and 64-byte map
`timescale 1ns/1ns
`default_nettype none
module mbh_host_port (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // host bus
  input wire mbh_pkg::mbh_bus_t bus,
  output logic [7:0] ad_out,
  output logic ad_oe_n,
  // status from the time-keeping side
  input wire mbh_pkg::mbh_stat_t stat,
  // decoded host style
  output logic rdwr_style
);
  import mbh_pkg::*;

  // strobe history for edge detection
  logic as_d_r;
  logic as_d_nxt;
  logic ds_d_r;
  logic ds_d_nxt;
  // detected host style
  mbh_style_t style_r;
  mbh_style_t style_nxt;
  // latched byte index
  logic [MBH_AW-1:0] idx_r;
  logic [MBH_AW-1:0] idx_nxt;
  // byte map, kept in flops so a read needs no extra wait
  logic [7:0] mem_r [MBH_DEPTH];
  logic [7:0] mem_nxt [MBH_DEPTH];
  // read data and output enable
  logic [7:0] dout_r;
  logic [7:0] dout_nxt;
  logic oe_n_r;
  logic oe_n_nxt;
  // decoded bus phases
  logic sel;
  logic rd_act;
  logic wr_act;
  logic wr_edge;
  logic time_locked;
  logic wr_take;
  logic rd_take;

  // true for the ten time, calendar and alarm bytes
  function automatic logic is_time(input logic [MBH_AW-1:0] a);
    return a <= MBH_TIME_LAST;
  endfunction : is_time

  // bytes that take no host write at all
  function automatic logic is_ro_byte(input logic [MBH_AW-1:0] a);
    return (a == MBH_IRQ_FLAGS) || (a == MBH_VALID_STAT);
  endfunction : is_ro_byte

  // bytes whose top bit is fixed against host writes
  function automatic logic has_ro_top(input logic [MBH_AW-1:0] a);
    return (a == MBH_DIV_CTRL) || (a == MBH_SECONDS);
  endfunction : has_ro_top

  // merge a host write into the stored byte, keeping the protected parts
  function automatic logic [7:0] wr_merge(input logic [MBH_AW-1:0] a, input logic [7:0] old_v, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (is_ro_byte(a)) begin
      v = old_v; // [RULE5]
    end else if (has_ro_top(a)) begin
      v[MBH_RO_BIT] = old_v[MBH_RO_BIT]; // [RULE6]
    end
    return v;
  endfunction : wr_merge

  // host view of one byte: status bytes come from the time-keeping side
  function automatic logic [7:0] rd_view(input logic [MBH_AW-1:0] a, input logic [7:0] stored, input mbh_stat_t s);
    logic [7:0] v;
    unique case (a)
      MBH_IRQ_FLAGS: begin
        v = s.irq_flags; // [RULE5]
      end
      MBH_VALID_STAT: begin
        v = s.valid_stat; // [RULE5]
      end
      MBH_SECONDS: begin
        v = stored;
        v[MBH_RO_BIT] = 1'b0; // [RULE7]
      end
      default: begin
        v = stored; // [RULE3] [RULE4]
      end
    endcase
    return v;
  endfunction : rd_view

  // one select for both styles: chip enabled and address phase over
  assign sel = !bus.chip_en_n && !bus.addr_latch_strobe;

  // strobe style: data strobe high opens the window, rw_pin high reads and low writes;
  // read/write-strobe style: data_strobe_pin is the active-low read, rw_pin the active-low write
  always_comb begin
    if (style_r == MBH_STYLE_STROBE) begin // [RULE1]
      rd_act = bus.data_strobe_pin && bus.rw_pin;
      wr_act = bus.data_strobe_pin && !bus.rw_pin;
      // the write lands as the data strobe falls, after the data had the whole window to settle
      wr_edge = ds_d_r && !bus.data_strobe_pin && !bus.rw_pin;
    end else begin
      rd_act = !bus.data_strobe_pin;
      wr_act = !bus.rw_pin;
      // level-sensitive: a held write strobe rewrites the same byte, the last value wins
      wr_edge = wr_act;
    end
  end

  // time bytes belong to the update while it runs
  assign time_locked = stat.update_busy && is_time(idx_r);
  assign wr_take = sel && wr_edge && !time_locked;
  // a read is ignored while the write strobe is also active, so a conflict never drives the bus
  assign rd_take = sel && rd_act && !wr_act;

  // strobe history
  always_comb begin
    as_d_nxt = bus.addr_latch_strobe;
    ds_d_nxt = bus.data_strobe_pin;
  end

  // reset levels match an idle strobe-style host, so no false fall follows reset
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      as_d_r <= 1'b0;
      ds_d_r <= 1'b0;
    end else begin
      as_d_r <= as_d_nxt;
      ds_d_r <= ds_d_nxt;
    end
  end

  // host style
  always_comb begin
    style_nxt = style_r;
    // data strobe low means strobe-style host, read strobe high means read/write style
    if (bus.addr_latch_strobe) begin
      style_nxt = bus.data_strobe_pin ? MBH_STYLE_RDWR : MBH_STYLE_STROBE; // [RULE1] [RULE2]
    end
  end

  // a strobe-style host is assumed until the first address phase shows otherwise
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      style_r <= MBH_STYLE_STROBE;
    end else begin
      style_r <= style_nxt;
    end
  end

  // byte index
  always_comb begin
    idx_nxt = idx_r;
    // first edge with the latch strobe low: the host must still hold the index on the bus
    if (as_d_r && !bus.addr_latch_strobe) begin
      idx_nxt = bus.ad_in[MBH_AW-1:0]; // [RULE10]
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      idx_r <= '0;
    end else begin
      idx_r <= idx_nxt;
    end
  end

  // byte map
  always_comb begin
    mem_nxt = mem_r;
    // a write aimed at the time bytes mid-update is dropped; storage bytes always accept it
    if (wr_take) begin // [RULE4] [RULE9]
      mem_nxt[idx_r] = wr_merge(idx_r, mem_r[idx_r], bus.ad_in);
    end
  end

  // reset clears the whole map; nothing here survives a reset
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      for (int unsigned i = 0; i < MBH_DEPTH; i++) begin
        mem_r[i] <= MBH_RESET_BYTE;
      end
    end else begin
      mem_r <= mem_nxt;
    end
  end

  // read data and enable
  always_comb begin
    dout_nxt = dout_r;
    oe_n_nxt = 1'b1;
    if (rd_take) begin
      oe_n_nxt = 1'b0;
      dout_nxt = rd_view(idx_r, mem_r[idx_r], stat);
      // undefined during the update; a fixed zero keeps the answer predictable
      if (time_locked) begin
        dout_nxt = MBH_RESET_BYTE; // [RULE8]
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      dout_r <= MBH_RESET_BYTE;
      oe_n_r <= 1'b1;
    end else begin
      dout_r <= dout_nxt;
      oe_n_r <= oe_n_nxt;
    end
  end

  // outputs straight from flops
  assign ad_out = dout_r;
  assign ad_oe_n = oe_n_r;
  assign rdwr_style = (style_r == MBH_STYLE_RDWR);
endmodule : mbh_host_port
`default_nettype wire

// ==== core/mbh_pkg.sv ====
// package for the multiplexed bus host port: map layout, struct carriers and states
// Notes on behaviour
// RULE1: the data/read strobe level seen while the address latch strobe is high picks strobe or read/write-strobe style.
// RULE2: a strobe-style host keeps its data strobe low and a read/write-strobe host its read strobe high during address latch.
// RULE3: the map is 64 bytes: 10 time/calendar/alarm bytes, four control/status bytes and 50 storage bytes.
// RULE4: every byte other than the read-only exceptions is written and read back directly.
// RULE5: the interrupt flag and validity status bytes are read-only and ignore host writes.
// RULE6: bit 7 of the divider control byte and bit 7 of the seconds byte ignore host writes.
// RULE7: a read of the seconds byte always returns zero in bit 7.
// RULE8: while the update owns the ten time bytes their reads are undefined and the host avoids them.
// RULE9: the 50 storage bytes stay readable and writable during the update.
// RULE10: a six-bit byte index is latched from the bus when the address latch strobe falls and selects the next data phase.
package mbh_pkg;
  localparam int unsigned MBH_DEPTH = 64;
  localparam int unsigned MBH_AW = 6;
  localparam logic [5:0] MBH_SECONDS = 6'h00;
  localparam logic [5:0] MBH_TIME_LAST = 6'h09;
  localparam logic [5:0] MBH_DIV_CTRL = 6'h0A;
  localparam logic [5:0] MBH_IRQ_FLAGS = 6'h0C;
  localparam logic [5:0] MBH_VALID_STAT = 6'h0D;
  localparam int unsigned MBH_RO_BIT = 7;
  localparam logic [7:0] MBH_RESET_BYTE = 8'h00;

  typedef enum logic {MBH_STYLE_STROBE, MBH_STYLE_RDWR} mbh_style_t;

  // bus pins as seen by the port
  typedef struct packed {
    logic addr_latch_strobe;
    logic data_strobe_pin;
    logic rw_pin;
    logic chip_en_n;
    logic [7:0] ad_in;
  } mbh_bus_t;

  // internal status bytes supplied by the time-keeping side
  typedef struct packed {
    logic update_busy;
    logic [7:0] irq_flags;
    logic [7:0] valid_stat;
  } mbh_stat_t;
endpackage : mbh_pkg

// ==== sim/mbh_host_port_chk.sv ====
// port checker for the host port
`timescale 1ns/1ns
`default_nettype none
module mbh_host_port_chk (
  // watched ports
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire mbh_pkg::mbh_bus_t bus,
  input wire logic [7:0] ad_out,
  input wire logic ad_oe_n,
  input wire mbh_pkg::mbh_stat_t stat,
  input wire logic rdwr_style
);
  import mbh_pkg::*;
  logic as_r;
  logic [5:0] ix_r;
  wire logic rd = !ad_oe_n;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  always_ff @(posedge core_clk) begin
    as_r <= bus.addr_latch_strobe;
    if (as_r && !bus.addr_latch_strobe) ix_r <= bus.ad_in[5:0];
  end
  style_a: assert property (bus.addr_latch_strobe |=> rdwr_style == $past(bus.data_strobe_pin)) else $error("style");
  oe_idle_a: assert property (bus.chip_en_n |=> !rd) else $error("oe");
  sec_b7_a: assert property (rd && ix_r == MBH_SECONDS |-> !ad_out[7]) else $error("b7");
  irq_ro_a: assert property (rd && ix_r == MBH_IRQ_FLAGS |-> ad_out == $past(stat.irq_flags)) else $error("irq");
  val_ro_a: assert property (rd && ix_r == MBH_VALID_STAT |-> ad_out == $past(stat.valid_stat)) else $error("vld");
  st_rd_a: assert property (!rdwr_style && !bus.chip_en_n && bus.data_strobe_pin && bus.rw_pin
    && !bus.addr_latch_strobe |=> rd) else $error("st rd");
  rw_rd_a: assert property (rdwr_style && !bus.chip_en_n && !bus.data_strobe_pin
    && !bus.addr_latch_strobe |=> rd) else $error("rw rd");
  busy_rd_a: assert property (rd && $past(stat.update_busy) && ix_r <= MBH_TIME_LAST |-> ad_out == 8'h00)
    else $error("busy");
endmodule : mbh_host_port_chk
bind mbh_host_port mbh_host_port_chk mbh_host_port_chk_i (.core_clk(core_clk), .sys_rst(sys_rst), .bus(bus),
  .ad_out(ad_out), .ad_oe_n(ad_oe_n), .stat(stat), .rdwr_style(rdwr_style));
`default_nettype wire

// ==== sim/mbh_cpu_model.sv ====
// multiplexed-bus processor model, one byte per access
`timescale 1ns/1ns
`default_nettype none
module mbh_cpu_model (
  // clock and bus
  input wire logic core_clk,
  output var mbh_pkg::mbh_bus_t bus,
  input wire logic [7:0] ad_out,
  input wire logic ad_oe_n
);
  logic sty = 1'b0;
  // output enable seen when the last access, read or write, sampled ad_out
  logic oe_seen = 1'b1;
  initial bus = '{1'b0, 1'b0, 1'b1, 1'b1, 8'h00};
  task automatic acc(input logic wr, input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge core_clk);
    bus <= '{1'b1, sty, 1'b1, 1'b0, {2'b00, a}};
    @(posedge core_clk);
    // index stays on the bus through the first low cycle of the latch strobe, where the port takes it
    bus.addr_latch_strobe <= 1'b0;
    @(posedge core_clk);
    bus.ad_in <= wr ? d : ~{2'b00, a};
    bus.data_strobe_pin <= sty ? wr : 1'b1;
    bus.rw_pin <= !wr;
    @(posedge core_clk);
    #1 q = ad_out;
    oe_seen = ad_oe_n;
    @(posedge core_clk);
    // strobe falls first so a strobe-style write still sees select and write level
    bus.data_strobe_pin <= sty;
    @(posedge core_clk);
    bus <= '{1'b0, sty, 1'b1, 1'b1, ~bus.ad_in};
  endtask : acc
endmodule : mbh_cpu_model
`default_nettype wire

// ==== sim/mbh_host_port_test.sv ====
// self-checking bench for the host port
`timescale 1ns/1ns
`default_nettype none
module mbh_host_port_test;
  import mbh_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  wire mbh_bus_t bus;
  mbh_stat_t stat = '{1'b0, 8'hA5, 8'h80};
  logic [7:0] ad_out, q;
  logic ad_oe_n, rdwr_style;
  int mismatches = 0, total_checks = 0;
  always #10 core_clk = ~core_clk;
  mbh_host_port mbh_host_port_i (.core_clk(core_clk), .sys_rst(sys_rst), .bus(bus), .ad_out(ad_out),
    .ad_oe_n(ad_oe_n), .stat(stat), .rdwr_style(rdwr_style));
  mbh_cpu_model mbh_cpu_model_i (.core_clk(core_clk), .bus(bus), .ad_out(ad_out), .ad_oe_n(ad_oe_n));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [7:0] exp_of(input logic [5:0] a, input logic [7:0] d);
    case (a)
      MBH_IRQ_FLAGS: return stat.irq_flags;
      MBH_VALID_STAT: return stat.valid_stat;
      MBH_SECONDS, MBH_DIV_CTRL: return {1'b0, d[6:0]};
      default: return d;
    endcase
  endfunction : exp_of
  task automatic t_map(input logic s);
    mbh_cpu_model_i.sty = s;
    for (int i = 0; i < MBH_DEPTH; i++) mbh_cpu_model_i.acc(1'b1, 6'(i), {2'b10, 6'(i) ^ {6{s}}}, q);
    chk({7'h00, mbh_cpu_model_i.oe_seen}, 8'h01);
    chk({7'h00, rdwr_style}, {7'h00, s});
    for (int i = 0; i < MBH_DEPTH; i++) begin
      mbh_cpu_model_i.acc(1'b0, 6'(i), 8'h00, q);
      chk(q, exp_of(6'(i), {2'b10, 6'(i) ^ {6{s}}}));
      chk({7'h00, mbh_cpu_model_i.oe_seen}, 8'h00);
    end
    $display("map test done, style %0d", s);
  endtask : t_map
  task automatic t_busy;
    @(posedge core_clk);
    stat.update_busy <= 1'b1;
    mbh_cpu_model_i.acc(1'b1, 6'h30, 8'h3C, q);
    mbh_cpu_model_i.acc(1'b0, 6'h30, 8'h00, q);
    chk(q, 8'h3C);
    mbh_cpu_model_i.acc(1'b0, 6'h05, 8'h00, q);
    chk(q, 8'h00);
    mbh_cpu_model_i.acc(1'b1, 6'h05, 8'h11, q);
    @(posedge core_clk);
    stat.update_busy <= 1'b0;
    mbh_cpu_model_i.acc(1'b0, 6'h05, 8'h00, q);
    chk(q, exp_of(6'h05, {2'b10, 6'h05 ^ 6'h3F}));
    $display("busy test done");
  endtask : t_busy
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done
  initial begin
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_map(1'b0);
    t_map(1'b1);
    t_busy;
    test_done;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    test_done;
  end
endmodule : mbh_host_port_test
`default_nettype wire
